// ### rtl/monitor_port_map.svh
`ifndef MONITOR_PORT_MAP_SVH
`define MONITOR_PORT_MAP_SVH
`define MON_BIT_CYCLES 256
`define MON_BREAK_BITS 10
`define MON_BREAK_LOW_BITS 9
`define MON_RECOVERY_BITS 2
`define MON_RESET_VEC_HI 16'hFEFE
`define MON_RESET_VEC_LO 16'hFEFF
`define MON_SWI_VEC_HI 16'hFEFC
`define MON_SWI_VEC_LO 16'hFEFD
`define USER_RESET_VEC_HI 16'hFFFE
`define USER_RESET_VEC_LO 16'hFFFF
`define USER_SWI_VEC_HI 16'hFFFC
`define USER_SWI_VEC_LO 16'hFFFD
`define CMD_READ 8'h4A
`define CMD_WRITE 8'h49
`define CMD_INDEXED_READ_CMD 8'h1A
`define CMD_INDEXED_WRITE_CMD 8'h19
`define CMD_SPREAD 8'h0C
`define CMD_RUN 8'h28
`endif

// ### rtl/monitor_port_pkg.sv
package monitor_port_pkg;
   typedef enum {CMD_IDLE, CMD_ADDR_HI, CMD_ADDR_LO, CMD_DATA, CMD_MEM, CMD_SEND} cmd_state_e;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK, TX_HIGH} tx_state_e;
   typedef logic [7:0] byte_t;
endpackage

// ### rtl/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 9);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// ### rtl/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   byte_stream_if.sink wr,
   byte_stream_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic [WIDTH-1:0] rdata;
   wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   wire empty = (wptr == rptr);
   wire push = wr.valid && !full;
   wire pop = rd.ready && !empty;
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = rdata;
   always_comb begin
      rdata = mem[rptr[AW-1:0]];
   end
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= wr.data;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wptr <= '0;
      end else if (push) begin
         wptr <= wptr + 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rptr <= '0;
      end else if (pop) begin
         rptr <= rptr + 1'b1;
      end
   end
endmodule // stream_fifo

// ### rtl/single_wire_monitor_port.sv
`timescale 1ns/1ps
`include "monitor_port_map.svh"
// What this block does
// R1: Monitor mode is latched from straps at reset release, then straps are ignored.
// R2: Divide select low: clock generator output equals crystal clock, bus is half.
// R3: Divide select high: bus is input clock divided by four, PLL needs this.
// R4: After monitor reset with the serial pin high at reset release, transmit a break of ten zero bits.
// R5: Monitor mode uses reset vector FEFE/FEFF and interrupt vector FEFC/FEFD.
// R6: Serial pin low at reset release starts execution at RAM base plus one.
// R7: Software interrupt from downloaded code returns control to monitor firmware.
// R8: Watchdog held disabled while high voltage present; enabled once removed.
// R9: Mark/space NRZ framing, same baud rate in both directions.
// R10: Received break: release pin high (pullup) two bit times, then echo the break.
// R11: Bit rate equals bus clock divided by 256.
// R12: Every received byte is echoed at once.
// R13: Read data is sent only after the last command byte echo completes.
// R14: Commands: read, write, indexed read/write, stack pointer read, run ($28).
// R15: Indexed commands step through consecutive addresses over 64 Kbytes.
// R16: Serial pin is wired-OR with pullup; never driven high actively.
// R17: Host re-establishes baud after PLL switches onto the bus.
// R18: Byte: low start bit, eight data bits LSB first, high stop bit.
module single_wire_monitor_port
   import monitor_port_pkg::*;
#(
   parameter int BIT_CYCLES = `MON_BIT_CYCLES,
   parameter int FIFO_DEPTH = 32,
   parameter logic [15:0] RAM_BASE = 16'h0040
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_reset_pin_n,
   input wire logic i_reset_pin_high_voltage,
   input wire logic i_high_voltage_entry_pin,
   input wire logic i_entry_strap_a,
   input wire logic i_entry_strap_b,
   input wire logic i_clock_divide_select_pin,
   input wire logic i_pll_selected,
   input wire logic i_monitor_serial_pin_in,
   output logic o_monitor_serial_pin_out,
   output logic o_monitor_serial_pin_oe,
   input wire logic i_software_interrupt,
   output logic o_monitor_mode,
   output logic o_ram_jump,
   output logic [15:0] o_start_address,
   output logic [15:0] o_reset_vector_hi,
   output logic [15:0] o_reset_vector_lo,
   output logic [15:0] o_swi_vector_hi,
   output logic [15:0] o_swi_vector_lo,
   output logic o_use_pll_clock,
   output logic [1:0] o_bus_divide,
   output logic o_clock_gen_bypass,
   output logic o_watchdog_enable,
   output logic o_mem_req,
   output logic o_mem_write,
   output logic [15:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [15:0] i_stack_pointer,
   output logic o_run_pulse
);
   initial begin
      if (BIT_CYCLES < 4) $error("BIT_CYCLES too small");
   end
   localparam int CW = $clog2(BIT_CYCLES + 1);

   // Pin synchronisers
   logic [1:0] rst_s, hv_s, hvr_s, sa_s, sb_s, cds_s, ser_s;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rst_s <= 2'h0;
         hv_s <= 2'h0;
         hvr_s <= 2'h0;
         sa_s <= 2'h0;
         sb_s <= 2'h0;
         cds_s <= 2'h0;
         ser_s <= 2'h3;
      end else begin
         rst_s <= {rst_s[0], i_reset_pin_n};
         hv_s <= {hv_s[0], i_high_voltage_entry_pin};
         hvr_s <= {hvr_s[0], i_reset_pin_high_voltage};
         sa_s <= {sa_s[0], i_entry_strap_a};
         sb_s <= {sb_s[0], i_entry_strap_b};
         cds_s <= {cds_s[0], i_clock_divide_select_pin};
         ser_s <= {ser_s[0], i_monitor_serial_pin_in};
      end
   end
   wire rx_pin = ser_s[1];
   logic rst_d;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rst_d <= 1'b0;
      end else begin
         rst_d <= rst_s[1];
      end
   end
   wire rst_rise = rst_s[1] && !rst_d;
   wire in_reset = !rst_s[1];

   // Mode latch at the rising edge of the reset pin
   logic div_sel;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_monitor_mode <= 1'b0;
         div_sel <= 1'b0;
         o_ram_jump <= 1'b0;
      end else if (rst_rise) begin
         o_monitor_mode <= hv_s[1] && sa_s[1] && !sb_s[1]; // [R1]
         div_sel <= cds_s[1]; // [R1]
         o_ram_jump <= !rx_pin; // [R6]
      end
   end
   always_comb begin
      o_clock_gen_bypass = o_monitor_mode && !div_sel; // [R2]
      o_bus_divide = (o_monitor_mode && !div_sel) ? 2'h2 : 2'h3; // [R2] [R3]
      o_use_pll_clock = o_monitor_mode && div_sel && i_pll_selected; // [R3]
      o_start_address = o_ram_jump ? RAM_BASE + 16'h0001 : `MON_RESET_VEC_HI; // [R6]
      o_reset_vector_hi = o_monitor_mode ? `MON_RESET_VEC_HI : `USER_RESET_VEC_HI; // [R5]
      o_reset_vector_lo = o_monitor_mode ? `MON_RESET_VEC_LO : `USER_RESET_VEC_LO; // [R5]
      o_swi_vector_hi = o_monitor_mode ? `MON_SWI_VEC_HI : `USER_SWI_VEC_HI; // [R5] [R7]
      o_swi_vector_lo = o_monitor_mode ? `MON_SWI_VEC_LO : `USER_SWI_VEC_LO; // [R5] [R7]
      o_watchdog_enable = !(hv_s[1] || hvr_s[1]); // [R8]
   end

   tx_state_e tx_state;
   wire tx_active = tx_state != TX_IDLE;
   // Receiver, sampling mid-bit on the common bit period
   logic rx_busy;
   logic [CW-1:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [8:0] rx_shift;
   logic rx_done;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || in_reset) begin
         rx_busy <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= 4'h0;
         rx_shift <= 9'h000;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (!rx_pin && o_monitor_mode && !tx_active) begin
               rx_busy <= 1'b1;
               rx_cnt <= CW'(BIT_CYCLES / 2);
               rx_bit <= 4'h0;
            end
         end else if (rx_cnt == '0) begin
            rx_cnt <= CW'(BIT_CYCLES - 1); // [R11]
            if (rx_bit == 4'h0 && rx_pin) begin
               rx_busy <= 1'b0;
            end else if (rx_bit == 4'h9) begin
               rx_busy <= 1'b0;
               rx_done <= 1'b1;
               rx_shift <= {rx_pin, rx_shift[8:1]}; // [R9] [R18]
            end else begin
               rx_bit <= rx_bit + 4'h1;
               if (rx_bit != 4'h0) begin
                  rx_shift <= {rx_pin, rx_shift[8:1]}; // [R18]
               end
            end
         end else begin
            rx_cnt <= rx_cnt - CW'(1);
         end
      end
   end
   wire [7:0] rx_byte = rx_shift[7:0];
   wire rx_break = rx_done && rx_shift == 9'h000; // [R10]

   // Transmit queue: bit 8 marks a break request
   byte_stream_if #(.WIDTH(9)) q_in ();
   byte_stream_if #(.WIDTH(9)) q_out ();
   stream_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn && !in_reset),
      .wr(q_in),
      .rd(q_out)
   );

   // Transmitter, open-drain: only ever pulls low
   logic [CW-1:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_level;
   assign q_out.ready = tx_state == TX_IDLE;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || in_reset) begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= 4'h0;
         tx_shift <= 8'h00;
         tx_level <= 1'b1;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               tx_level <= 1'b1;
               if (q_out.valid) begin
                  tx_cnt <= CW'(BIT_CYCLES - 1);
                  tx_bit <= 4'h0;
                  if (q_out.data[8]) begin
                     tx_level <= q_out.data[0];
                     tx_state <= q_out.data[0] ? TX_HIGH : TX_BREAK; // [R10]
                  end else begin
                     tx_shift <= q_out.data[7:0];
                     tx_level <= 1'b0; // [R18]
                     tx_state <= TX_DATA;
                  end
               end
            end
            TX_HIGH: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= CW'(BIT_CYCLES - 1);
                  if (tx_bit == 4'(`MON_RECOVERY_BITS - 1)) begin
                     tx_bit <= 4'h0;
                     tx_level <= 1'b0;
                     tx_state <= TX_BREAK; // [R10]
                  end else begin
                     tx_bit <= tx_bit + 4'h1;
                  end
               end else begin
                  tx_cnt <= tx_cnt - CW'(1);
               end
            end
            TX_BREAK: begin
               tx_level <= 1'b0;
               if (tx_cnt == '0) begin
                  tx_cnt <= CW'(BIT_CYCLES - 1);
                  if (tx_bit == 4'(`MON_BREAK_BITS - 1)) begin
                     tx_level <= 1'b1;
                     tx_state <= TX_STOP; // [R4]
                  end else begin
                     tx_bit <= tx_bit + 4'h1;
                  end
               end else begin
                  tx_cnt <= tx_cnt - CW'(1);
               end
            end
            TX_DATA: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= CW'(BIT_CYCLES - 1); // [R11]
                  if (tx_bit == 4'h8) begin
                     tx_level <= 1'b1; // [R18]
                     tx_state <= TX_STOP;
                  end else begin
                     tx_level <= tx_shift[0]; // [R18]
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     tx_bit <= tx_bit + 4'h1;
                  end
               end else begin
                  tx_cnt <= tx_cnt - CW'(1);
               end
            end
            TX_STOP: begin
               if (tx_cnt == '0) begin
                  tx_state <= TX_IDLE;
               end else begin
                  tx_cnt <= tx_cnt - CW'(1);
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end
   assign o_monitor_serial_pin_out = 1'b0; // [R16]
   assign o_monitor_serial_pin_oe = !tx_level; // [R16]

   // Command engine
   cmd_state_e cmd_state;
   byte_t opcode;
   logic [15:0] addr;
   logic [15:0] ix_addr;
   logic [1:0] send_left;
   logic [15:0] send_word;
   logic boot_break;
   logic mem_pend;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || in_reset) begin
         boot_break <= 1'b0;
      end else if (!rst_rise && o_monitor_mode && !o_ram_jump) begin // [R4] [R6]
         boot_break <= 1'b1;
      end
   end
   logic swi_break;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || in_reset) begin
         swi_break <= 1'b0;
      end else begin
         swi_break <= o_monitor_mode && i_software_interrupt; // [R7]
      end
   end
   wire boot_req = o_monitor_mode && !o_ram_jump && !boot_break && !rst_rise; // [R4] [R6]
   always_comb begin
      q_in.valid = 1'b0;
      q_in.data = 9'h000;
      if (rx_break) begin
         q_in.valid = 1'b1;
         q_in.data = 9'h101; // [R10]
      end else if (rx_done) begin
         q_in.valid = 1'b1;
         q_in.data = {1'b0, rx_byte}; // [R12]
      end else if (boot_req || swi_break) begin
         q_in.valid = 1'b1;
         q_in.data = 9'h100; // [R4] [R7]
      end else if (cmd_state == CMD_SEND && !tx_active && !q_out.valid) begin
         q_in.valid = 1'b1; // [R13]
         q_in.data = {1'b0, send_word[15:8]};
      end
   end
   assign o_mem_req = mem_pend;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || in_reset) begin
         cmd_state <= CMD_IDLE;
         opcode <= 8'h00;
         addr <= 16'h0000;
         ix_addr <= 16'h0000;
         send_left <= 2'h0;
         send_word <= 16'h0000;
         mem_pend <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_addr <= 16'h0000;
         o_mem_wdata <= 8'h00;
         o_run_pulse <= 1'b0;
      end else begin
         mem_pend <= 1'b0;
         o_run_pulse <= 1'b0;
         case (cmd_state)
            CMD_IDLE: begin
               if (rx_done && !rx_break) begin
                  opcode <= rx_byte;
                  case (rx_byte) // [R14]
                     `CMD_READ, `CMD_WRITE: cmd_state <= CMD_ADDR_HI;
                     `CMD_INDEXED_WRITE_CMD: cmd_state <= CMD_DATA;
                     `CMD_INDEXED_READ_CMD: begin
                        o_mem_addr <= ix_addr; // [R15]
                        o_mem_write <= 1'b0;
                        mem_pend <= 1'b1;
                        cmd_state <= CMD_MEM;
                     end
                     `CMD_SPREAD: begin
                        send_word <= i_stack_pointer;
                        send_left <= 2'h2;
                        cmd_state <= CMD_SEND;
                     end
                     `CMD_RUN: o_run_pulse <= 1'b1; // [R14]
                     default: cmd_state <= CMD_IDLE;
                  endcase
               end
            end
            CMD_ADDR_HI: if (rx_done) begin
               addr[15:8] <= rx_byte;
               cmd_state <= CMD_ADDR_LO;
            end
            CMD_ADDR_LO: if (rx_done) begin
               addr[7:0] <= rx_byte;
               if (opcode == `CMD_WRITE) begin
                  cmd_state <= CMD_DATA;
               end else begin
                  o_mem_addr <= {addr[15:8], rx_byte};
                  o_mem_write <= 1'b0;
                  mem_pend <= 1'b1;
                  cmd_state <= CMD_MEM;
               end
            end
            CMD_DATA: if (rx_done) begin
               o_mem_addr <= opcode == `CMD_WRITE ? addr : ix_addr;
               o_mem_wdata <= rx_byte;
               o_mem_write <= 1'b1;
               mem_pend <= 1'b1;
               ix_addr <= (opcode == `CMD_WRITE ? addr : ix_addr) + 16'h0001; // [R15]
               cmd_state <= CMD_IDLE;
            end
            CMD_MEM: begin
               send_word <= {i_mem_rdata, 8'h00};
               send_left <= 2'h1;
               ix_addr <= o_mem_addr + 16'h0001; // [R15]
               cmd_state <= CMD_SEND;
            end
            CMD_SEND: if (q_in.valid && q_in.ready && !rx_done && !boot_req && !swi_break) begin
               send_word <= {send_word[7:0], 8'h00};
               send_left <= send_left - 2'h1;
               if (send_left == 2'h1) begin
                  cmd_state <= CMD_IDLE;
               end
            end
            default: cmd_state <= CMD_IDLE;
         endcase
      end
   end
endmodule // single_wire_monitor_port

// ### tb/single_wire_monitor_port_sva.sv
`timescale 1ns/1ps
module single_wire_monitor_port_sva #(
   parameter int BIT_CYCLES = 256,
   parameter logic [15:0] RAM_BASE = 16'h0040
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_reset_pin_n,
   input wire logic i_reset_pin_high_voltage,
   input wire logic i_high_voltage_entry_pin,
   input wire logic o_monitor_serial_pin_out,
   input wire logic o_monitor_serial_pin_oe,
   input wire logic o_monitor_mode,
   input wire logic o_ram_jump,
   input wire logic [15:0] o_start_address,
   input wire logic [15:0] o_reset_vector_hi,
   input wire logic [15:0] o_swi_vector_lo,
   input wire logic o_use_pll_clock,
   input wire logic [1:0] o_bus_divide,
   input wire logic o_watchdog_enable
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   int low_run;
   // Length of the current pull-low run
   always_ff @(posedge i_clk) begin
      if (!i_resetn || !o_monitor_serial_pin_oe) low_run <= 0;
      else low_run <= low_run + 1;
   end
   sequence s_pin_settled;
      (i_resetn && i_reset_pin_n)[*8];
   endsequence
   sequence s_hv_on;
      (i_high_voltage_entry_pin || i_reset_pin_high_voltage)[*5];
   endsequence
   sequence s_hv_off;
      (!i_high_voltage_entry_pin && !i_reset_pin_high_voltage)[*5];
   endsequence
   chk_pin_never_high: assert property (o_monitor_serial_pin_oe |-> !o_monitor_serial_pin_out)
      else $error("serial pin driven high");
   chk_mode_hold: assert property (s_pin_settled |=> $stable(o_monitor_mode) && $stable(o_ram_jump))
      else $error("mode changed without reset edge");
   chk_monitor_vectors: assert property (o_monitor_mode |-> o_reset_vector_hi == 16'hFEFE && o_swi_vector_lo == 16'hFEFD)
      else $error("wrong monitor vectors");
   chk_start_address: assert property (o_monitor_mode |-> o_start_address == (o_ram_jump ? RAM_BASE + 16'h0001 : 16'hFEFE))
      else $error("wrong start address");
   chk_watchdog_off: assert property (s_hv_on |-> !o_watchdog_enable)
      else $error("watchdog on under high voltage");
   chk_watchdog_on: assert property (s_hv_off |-> o_watchdog_enable)
      else $error("watchdog off without high voltage");
   chk_pll_quarter: assert property (o_use_pll_clock |-> o_bus_divide == 2'h3)
      else $error("pll bus not quartered");
   chk_bit_run: assert property ($fell(o_monitor_serial_pin_oe) |-> low_run % BIT_CYCLES == 0 && low_run <= 10 * BIT_CYCLES)
      else $error("low run not whole bits");
endmodule // single_wire_monitor_port_sva

// ### tb/host_line_model.sv
`timescale 1ns/1ps
module host_line_model #(parameter int BITS = 16) (
   input wire logic i_clk,
   input wire logic i_line,
   output logic o_pull_low
);
   initial o_pull_low = 1'b0;
   // Only ever pulls low; stop bit comes from the pullup
   task automatic send(input logic [7:0] b, input logic brk);
      logic [9:0] f;
      f = brk ? 10'h000 : {1'b1, b, 1'b0};
      for (int i = 0; i < (brk ? 10 : 9); i++) begin
         o_pull_low <= ~f[i];
         repeat (BITS) @(posedge i_clk);
      end
      o_pull_low <= 1'b0;
      @(posedge i_clk);
   endtask
   // Returns stop bit in v[8]
   task automatic recv(output logic [8:0] v, output logic ok);
      int n;
      n = 0;
      while (i_line !== 1'b0 && n < 40 * BITS) begin
         @(posedge i_clk);
         n++;
      end
      ok = n < 40 * BITS;
      repeat (BITS / 2) @(posedge i_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BITS) @(posedge i_clk);
         v[i] = i_line;
      end
      repeat (BITS / 2) @(posedge i_clk);
   endtask
endmodule // host_line_model

// ### tb/tb_single_wire_monitor_port.sv
`timescale 1ns/1ps
module tb_single_wire_monitor_port;
   import monitor_port_pkg::*;
   localparam int BITS = 16;
   localparam logic [15:0] RAM_BASE = 16'h0040;
   logic i_clk;
   logic i_resetn = 1'b0, i_reset_pin_n = 1'b0, i_reset_pin_high_voltage = 1'b0;
   logic i_high_voltage_entry_pin = 1'b0, i_entry_strap_a = 1'b0, i_entry_strap_b = 1'b0;
   logic i_clock_divide_select_pin = 1'b0, i_pll_selected = 1'b0, i_software_interrupt = 1'b0;
   byte_t i_mem_rdata;
   logic [15:0] i_stack_pointer = 16'hA5C3;
   logic o_monitor_serial_pin_out, o_monitor_serial_pin_oe, o_monitor_mode, o_ram_jump;
   logic o_use_pll_clock, o_watchdog_enable, o_mem_req, o_mem_write, o_run_pulse, o_clock_gen_bypass;
   logic [15:0] o_start_address, o_reset_vector_hi, o_swi_vector_lo, o_mem_addr, waddr;
   logic [15:0] o_reset_vector_lo, o_swi_vector_hi;
   logic [1:0] o_bus_divide;
   byte_t o_mem_wdata, wdata;
   logic host_pull, line, run_seen = 1'b0;
   int cyc = 0, n_mismatch = 0, samples_checked = 0;
   assign line = ~((o_monitor_serial_pin_oe & ~o_monitor_serial_pin_out) | host_pull);
   single_wire_monitor_port #(.BIT_CYCLES(BITS), .RAM_BASE(RAM_BASE)) u_dut (
      .i_clk, .i_resetn, .i_reset_pin_n, .i_reset_pin_high_voltage, .i_high_voltage_entry_pin,
      .i_entry_strap_a, .i_entry_strap_b, .i_clock_divide_select_pin, .i_pll_selected,
      .i_monitor_serial_pin_in(line), .o_monitor_serial_pin_out, .o_monitor_serial_pin_oe,
      .i_software_interrupt, .o_monitor_mode, .o_ram_jump, .o_start_address, .o_reset_vector_hi,
      .o_reset_vector_lo, .o_swi_vector_hi, .o_swi_vector_lo, .o_use_pll_clock, .o_bus_divide,
      .o_clock_gen_bypass, .o_watchdog_enable, .o_mem_req, .o_mem_write, .o_mem_addr, .o_mem_wdata,
      .i_mem_rdata, .i_stack_pointer, .o_run_pulse);
   host_line_model #(.BITS(BITS)) u_host (.i_clk, .i_line(line), .o_pull_low(host_pull));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   function automatic byte_t mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   // Memory answers within the request cycle
   assign i_mem_rdata = mem_val(o_mem_addr);
   // Memory stand-in and cycle limit
   always @(posedge i_clk) begin
      cyc++;
      if (o_mem_req && o_mem_write) waddr <= o_mem_addr;
      if (o_mem_req && o_mem_write) wdata <= o_mem_wdata;
      if (o_run_pulse) run_seen <= 1'b1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic expect_rx(input logic [9:0] e);
      logic [8:0] v;
      logic ok;
      u_host.recv(v, ok);
      check({ok, v}, e);
   endtask
   task automatic seq(input logic [31:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         u_host.send(b[8*i +: 8], 1'b0);
         expect_rx({2'b11, b[8*i +: 8]});
      end
   endtask
   task automatic enter(input logic sel, input logic jump);
      i_reset_pin_n <= 1'b0;
      i_entry_strap_a <= 1'b1;
      i_high_voltage_entry_pin <= 1'b1;
      i_clock_divide_select_pin <= sel;
      u_host.o_pull_low <= jump;
      repeat (8) @(posedge i_clk);
      i_reset_pin_n <= 1'b1;
      if (jump) repeat (8) @(posedge i_clk);
      else expect_rx(10'h200);
      u_host.o_pull_low <= 1'b0;
      i_entry_strap_a <= 1'b0;
      i_clock_divide_select_pin <= ~sel;
      repeat (4) @(posedge i_clk);
      check(o_monitor_mode, 1'b1);
      check(o_ram_jump, jump);
      check(o_bus_divide, sel ? 2'h3 : 2'h2);
      check(o_start_address, jump ? RAM_BASE + 16'h0001 : 16'hFEFE);
      check(o_reset_vector_hi, 16'hFEFE);
      check(o_swi_vector_lo, 16'hFEFD);
      check(o_reset_vector_lo, 16'hFEFF);
      check(o_swi_vector_hi, 16'hFEFC);
      check(o_clock_gen_bypass, !sel);
   endtask
   task automatic t_watchdog;
      check(o_watchdog_enable, 1'b0);
      i_high_voltage_entry_pin <= 1'b0;
      repeat (6) @(posedge i_clk);
      check(o_watchdog_enable, 1'b1);
      i_reset_pin_high_voltage <= 1'b1;
      i_pll_selected <= 1'b1;
      repeat (6) @(posedge i_clk);
      check(o_watchdog_enable, 1'b0);
      check(o_use_pll_clock, 1'b1);
      i_reset_pin_high_voltage <= 1'b0;
      i_pll_selected <= 1'b0;
   endtask
   task automatic t_commands;
      seq(32'h4912345A, 4);
      check(waddr, 16'h1234);
      check(wdata, 8'h5A);
      seq(32'h1A, 1);
      expect_rx({2'b11, mem_val(16'h1235)});
      seq(32'h1A, 1);
      expect_rx({2'b11, mem_val(16'h1236)});
      seq(32'h1977, 2);
      check(waddr, 16'h1237);
      check(wdata, 8'h77);
      seq(32'h4AFFFE, 3);
      expect_rx({2'b11, mem_val(16'hFFFE)});
      seq(32'h0C, 1);
      expect_rx({2'b11, i_stack_pointer[15:8]});
      expect_rx({2'b11, i_stack_pointer[7:0]});
      check(run_seen, 1'b0);
      seq(32'h28, 1);
      repeat (4) @(posedge i_clk);
      check(run_seen, 1'b1);
   endtask
   task automatic t_host_break;
      u_host.send(8'h00, 1'b1);
      repeat (BITS) @(posedge i_clk);
      check(line, 1'b1);
      expect_rx(10'h200);
   endtask
   task automatic t_swi;
      i_software_interrupt <= 1'b1;
      @(posedge i_clk);
      i_software_interrupt <= 1'b0;
      expect_rx(10'h200);
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      enter(1'b1, 1'b0);
      t_watchdog();
      t_commands();
      t_host_break();
      t_swi();
      enter(1'b0, 1'b1);
      end_sim();
   end
endmodule // tb_single_wire_monitor_port
bind single_wire_monitor_port single_wire_monitor_port_sva #(.BIT_CYCLES(BIT_CYCLES), .RAM_BASE(RAM_BASE)) u_sva (
   .i_clk, .i_resetn, .i_reset_pin_n, .i_reset_pin_high_voltage, .i_high_voltage_entry_pin,
   .o_monitor_serial_pin_out, .o_monitor_serial_pin_oe, .o_monitor_mode, .o_ram_jump, .o_start_address,
   .o_reset_vector_hi, .o_swi_vector_lo, .o_use_pll_clock, .o_bus_divide, .o_watchdog_enable);
